// ===== eepc_assertions.sv
// Checker: relations on the link between controller and device ends.
// Assumes one clock domain and the device's control outputs wired in.
`default_nettype none
module eepc_assertions #(
    parameter int unsigned FALL_CYC = 40,
    parameter int unsigned PULSE_MIN = 400
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic pump_on_o,
    input wire logic prog_power_o,
    input wire logic [1:0] erase_mode_o
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic ctrl_wr;
    logic array_wr;
    logic latch_q;
    logic [15:0] off_cnt_q;
    logic [15:0] on_cnt_q;
    assign ctrl_wr = wr && (addr == eepc_pkg::PROG_CTRL_OFFSET);
    assign array_wr = wr && (addr >= eepc_pkg::ARRAY_BASE) && (addr < 16'h01c0);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_q <= 1'b0;
        end else if (ctrl_wr) begin
            latch_q <= wdata[eepc_pkg::BIT_LATCH];
        end
    end
    // Saturating, so a long idle spell never wraps into a false short count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            off_cnt_q <= 16'h0000;
        end else if (prog_power_o) begin
            off_cnt_q <= 16'h0000;
        end else if (off_cnt_q != 16'hffff) begin
            off_cnt_q <= off_cnt_q + 16'h0001;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_cnt_q <= 16'h0000;
        end else if (!prog_power_o) begin
            on_cnt_q <= 16'h0000;
        end else if (on_cnt_q != 16'hffff) begin
            on_cnt_q <= on_cnt_q + 16'h0001;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_pump_bit_follows: assert property (ctrl_wr |=> pump_on_o == $past(wdata[0]))
        else $error("pump output does not follow control write");
    chk_mode_field_follows: assert property (ctrl_wr |=> erase_mode_o == $past(wdata[2:1]))
        else $error("erase mode output does not follow control write");
    chk_latch_drops_power: assert property (ctrl_wr && !wdata[3] |=> !prog_power_o)
        else $error("power stayed on after latch cleared");
    chk_power_when_latched: assert property (
        ctrl_wr && latch_q && wdata[3] |=> prog_power_o == $past(wdata[5]))
        else $error("power bit write while latched not applied");
    chk_power_rise_ready: assert property (
        $rose(prog_power_o) |-> pump_on_o && latch_q)
        else $error("power rose without pump and latch");
    chk_fall_wait_kept: assert property (
        ctrl_wr && latch_q && !wdata[3] |-> !prog_power_o && off_cnt_q >= FALL_CYC)
        else $error("latch cleared before fall time");
    chk_pulse_long_enough: assert property ($fell(prog_power_o) |-> on_cnt_q >= PULSE_MIN)
        else $error("power pulse shorter than shortest duration");
    chk_array_wr_latched: assert property (array_wr |-> latch_q ##1 !prog_power_o)
        else $error("array written while not latched");
    chk_latch_with_pump: assert property (ctrl_wr && wdata[3] && !latch_q |-> wdata[0])
        else $error("latch set without pump enable");
    cover property ($rose(prog_power_o));
    cover property (array_wr ##[1:4] ctrl_wr && wdata[5]);
    cover property (rd ##1 rdata == 8'hff);
endmodule : eepc_assertions
`default_nettype wire

// ===== eepc_ctl.sv
// Controller end: runs program/erase sequences on command from software.
// Assumes software uses the plain register port; one operation at a time.
//
// Our own choice: the plain strobed port.
`default_nettype none
module eepc_ctl #(
    parameter int unsigned PROGRAM_CYC = 400,
    parameter int unsigned BYTE_ERASE_CYC = 400,
    parameter int unsigned BLOCK_ERASE_CYC = 400,
    parameter int unsigned BULK_ERASE_CYC = 400,
    parameter int unsigned FALL_CYC = 40
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    eepc_if.ctl bus,
    input wire logic [3:0] sw_addr_i,
    input wire logic [7:0] sw_wdata_i,
    input wire logic sw_wr_i,
    input wire logic sw_rd_i,
    output logic [7:0] sw_rdata_o
);
    initial begin
        if (FALL_CYC < 1 || PROGRAM_CYC < 1) $error("durations must be positive");
    end

    typedef enum logic [2:0] {
        EEPC_IDLE = 3'b000, EEPC_SETUP = 3'b001, EEPC_WRITE = 3'b011,
        EEPC_POWER = 3'b010, EEPC_PULSE = 3'b110, EEPC_FALL = 3'b111,
        EEPC_RELEASE = 3'b101, EEPC_CLEAR = 3'b100
    } eepc_state_type;

    eepc_state_type state_q;
    logic [7:0] addr_q;
    logic [7:0] data_q;
    logic [1:0] mode_q;
    logic [23:0] cnt_q;
    logic [7:0] rdata_q;
    logic done_q;
    logic rc_q;
    logic [15:0] b_addr_q;
    logic [7:0] b_wdata_q;
    logic b_wr_q;

    // Mode pulse lengths as parameters
    function automatic logic [23:0] pulse_len(input logic [1:0] m);
        case (m)
            2'b00: pulse_len = 24'(PROGRAM_CYC);
            2'b01: pulse_len = 24'(BYTE_ERASE_CYC);
            2'b10: pulse_len = 24'(BLOCK_ERASE_CYC);
            default: pulse_len = 24'(BULK_ERASE_CYC);
        endcase
    endfunction : pulse_len

    function automatic logic [7:0] ctrl(input logic [1:0] m, input logic pwr);
        ctrl = 8'h00;
        ctrl[eepc_pkg::BIT_PUMP] = 1'b1;
        ctrl[eepc_pkg::BIT_LATCH] = 1'b1;
        ctrl[eepc_pkg::BIT_ERASE_HI:eepc_pkg::BIT_ERASE_LO] = m;
        ctrl[eepc_pkg::BIT_POWER] = pwr;
        ctrl[eepc_pkg::BIT_RC] = rc_q;
    endfunction : ctrl

    wire logic busy = (state_q != EEPC_IDLE);
    wire logic go = sw_wr_i && (sw_addr_i == eepc_pkg::CMD_GO) && !busy;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= EEPC_IDLE;
            cnt_q <= 24'h000000;
            b_addr_q <= 16'h0000;
            b_wdata_q <= 8'h00;
            b_wr_q <= 1'b0;
            mode_q <= 2'b00;
            rc_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            b_wr_q <= 1'b0;
            case (state_q)
                EEPC_IDLE: begin
                    if (go) begin
                        mode_q <= sw_wdata_i[1:0];
                        rc_q <= sw_wdata_i[2];
                        done_q <= 1'b0;
                        state_q <= EEPC_SETUP;
                    end else if (sw_wr_i && (sw_addr_i == eepc_pkg::CMD_OPTLO ||
                            sw_addr_i == eepc_pkg::CMD_OPTHI)) begin
                        // Sent in any mode; the device alone decides whether it lands
                        b_addr_q <= (sw_addr_i == eepc_pkg::CMD_OPTLO) ?
                            eepc_pkg::OPTION_LOW_OFFSET : eepc_pkg::OPTION_HIGH_OFFSET;
                        b_wdata_q <= sw_wdata_i;
                        b_wr_q <= 1'b1;
                    end
                end
                EEPC_SETUP: begin
                    b_addr_q <= eepc_pkg::PROG_CTRL_OFFSET;
                    b_wdata_q <= ctrl(mode_q, 1'b0);
                    b_wr_q <= 1'b1;
                    state_q <= EEPC_WRITE;
                end
                EEPC_WRITE: begin
                    b_addr_q <= eepc_pkg::ARRAY_BASE + {9'h000, addr_q[6:0]};
                    // Erase data is a don't-care; program data is taken as given
                    b_wdata_q <= data_q;
                    b_wr_q <= 1'b1;
                    state_q <= EEPC_POWER;
                end
                EEPC_POWER: begin
                    b_addr_q <= eepc_pkg::PROG_CTRL_OFFSET;
                    b_wdata_q <= ctrl(mode_q, 1'b1);
                    b_wr_q <= 1'b1;
                    cnt_q <= pulse_len(mode_q);
                    state_q <= EEPC_PULSE;
                end
                EEPC_PULSE: begin
                    if (cnt_q == 24'h000000) begin
                        b_wdata_q <= ctrl(mode_q, 1'b0);
                        b_wr_q <= 1'b1;
                        cnt_q <= 24'(FALL_CYC);
                        state_q <= EEPC_FALL;
                    end else cnt_q <= cnt_q - 24'h000001;
                end
                EEPC_FALL: begin
                    if (cnt_q == 24'h000000) state_q <= EEPC_RELEASE;
                    else cnt_q <= cnt_q - 24'h000001;
                end
                EEPC_RELEASE: begin
                    b_wdata_q <= 8'h00;
                    b_wr_q <= 1'b1;
                    state_q <= EEPC_CLEAR;
                end
                EEPC_CLEAR: begin
                    done_q <= 1'b1;
                    state_q <= EEPC_IDLE;
                end
                default: state_q <= EEPC_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_q <= 8'h00;
            data_q <= 8'h00;
        end else if (sw_wr_i && !busy) begin
            if (sw_addr_i == eepc_pkg::CMD_ADDR) addr_q <= sw_wdata_i;
            if (sw_addr_i == eepc_pkg::CMD_DATA) data_q <= sw_wdata_i;
        end
    end

    // Reads pass through to the device only while idle; answer is next cycle
    wire logic sw_pass = sw_rd_i && !busy && (sw_addr_i == eepc_pkg::CMD_RDATA ||
        sw_addr_i == eepc_pkg::CMD_OPTLO || sw_addr_i == eepc_pkg::CMD_OPTHI);
    logic pass_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
            pass_q <= 1'b0;
        end else begin
            pass_q <= sw_pass;
            if (sw_rd_i && sw_addr_i == eepc_pkg::CMD_STATUS) rdata_q <= {6'h00, done_q, busy};
            else if (sw_rd_i && sw_addr_i == eepc_pkg::CMD_ADDR) rdata_q <= addr_q;
            else if (sw_rd_i && sw_addr_i == eepc_pkg::CMD_DATA) rdata_q <= data_q;
            else rdata_q <= 8'h00;
        end
    end
    assign sw_rdata_o = pass_q ? bus.rdata : rdata_q;

    assign bus.addr = sw_pass ? (sw_addr_i == eepc_pkg::CMD_OPTLO ? eepc_pkg::OPTION_LOW_OFFSET :
        sw_addr_i == eepc_pkg::CMD_OPTHI ? eepc_pkg::OPTION_HIGH_OFFSET :
        eepc_pkg::ARRAY_BASE + {9'h000, addr_q[6:0]}) : b_addr_q;
    assign bus.rd = sw_pass;
    assign bus.wr = b_wr_q;
    assign bus.wdata = b_wdata_q;
endmodule : eepc_ctl
`default_nettype wire

// ===== eepc_device.sv
// Device end: program control register, 128-byte array, option bytes.
// Assumes the controller keeps the program/erase sequence; pump is digital here.
`default_nettype none
module eepc_device #(
    parameter int unsigned POR_CYC = eepc_pkg::REFRESH_POR_CYC,
    parameter int unsigned RUN_CYC = eepc_pkg::REFRESH_RUN_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    eepc_if.dev bus,
    input wire logic por_active_i,
    input wire logic bootloader_i,
    input wire logic stop_mode_i,
    output logic pump_on_o,
    output logic rc_clock_select_o,
    output logic rc_osc_run_o,
    output logic prog_power_o,
    output logic [1:0] erase_mode_o,
    output logic watchdog_option_o,
    output logic irq_sensitivity_option_o,
    output logic bit_order_option_o,
    output logic [1:0] serial_rate_o,
    output logic stop_to_halt_option_o,
    output logic low_voltage_reset_option_o,
    output logic clock_output_option_o,
    output logic [7:0] port_a_pullup_option_o
);
    initial begin
        if (POR_CYC < 2 || RUN_CYC < 2) $error("refresh counts too small");
    end

    logic [7:0] ctrl_q;
    logic [7:0] mem_q [0:eepc_pkg::ARRAY_BYTES-1];
    logic [6:0] lat_addr_q;
    logic [7:0] lat_data_q;
    logic captured_q;
    logic done_q;
    logic [7:0] opt_cell_q [0:1];
    logic [7:0] opt_lat_q [0:1];
    logic [23:0] ref_cnt_q;
    logic [7:0] rdata_q;

    function automatic logic in_array(input logic [15:0] a);
        in_array = (a >= eepc_pkg::ARRAY_BASE) &&
            (a < eepc_pkg::ARRAY_BASE + 16'(eepc_pkg::ARRAY_BYTES));
    endfunction : in_array

    wire logic latch = ctrl_q[eepc_pkg::BIT_LATCH];
    wire logic power = ctrl_q[eepc_pkg::BIT_POWER];
    wire logic [1:0] mode = ctrl_q[eepc_pkg::BIT_ERASE_HI:eepc_pkg::BIT_ERASE_LO];
    wire logic ctrl_wr = bus.wr && (bus.addr == eepc_pkg::PROG_CTRL_OFFSET);
    wire logic [15:0] arr_off = bus.addr - eepc_pkg::ARRAY_BASE;

    // ----------------------------------------
    // Program control register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= eepc_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q[4:0] <= bus.wdata[4:0];
            // Power needs latch already set; clearing latch drops it
            if (!bus.wdata[eepc_pkg::BIT_LATCH]) begin
                ctrl_q[eepc_pkg::BIT_POWER] <= 1'b0;
            end else if (latch) begin
                ctrl_q[eepc_pkg::BIT_POWER] <= bus.wdata[eepc_pkg::BIT_POWER];
            end
            ctrl_q[7:6] <= 2'b00;
        end
    end

    // ----------------------------------------
    // Address/data capture
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            captured_q <= 1'b0;
            lat_addr_q <= 7'h00;
            lat_data_q <= 8'h00;
        end else if (!latch) begin
            captured_q <= 1'b0;
        end else if (bus.wr && in_array(bus.addr)) begin
            captured_q <= 1'b1;
            lat_addr_q <= arr_off[6:0];
            lat_data_q <= bus.wdata;
        end
    end

    // ----------------------------------------
    // Array update on rising programming power
    // ----------------------------------------
    // Acts once per power pulse; pulse length is the controller's concern
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= power;
        end
    end

    always_ff @(posedge clk_i) begin
        if (power && !done_q && captured_q) begin
            for (int i = 0; i < eepc_pkg::ARRAY_BYTES; i++) begin
                case (eepc_mode_cast(mode))
                    eepc_pkg::EEPC_PROGRAM: begin
                        if (7'(i) == lat_addr_q) mem_q[i] <= mem_q[i] & lat_data_q;
                    end
                    eepc_pkg::EEPC_BYTE_ERASE: begin
                        if (7'(i) == lat_addr_q) mem_q[i] <= eepc_pkg::ERASED_BYTE;
                    end
                    eepc_pkg::EEPC_BLOCK_ERASE: begin
                        if (2'(i / eepc_pkg::BLOCK_BYTES) == lat_addr_q[6:5]) begin
                            mem_q[i] <= eepc_pkg::ERASED_BYTE;
                        end
                    end
                    default: begin
                        mem_q[i] <= eepc_pkg::ERASED_BYTE;
                    end
                endcase
            end
        end
    end

    function automatic eepc_pkg::eepc_mode_type eepc_mode_cast(input logic [1:0] m);
        eepc_mode_cast = eepc_pkg::eepc_mode_type'(m);
    endfunction : eepc_mode_cast

    // ----------------------------------------
    // Option bytes: cells and refreshed latches
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opt_cell_q[0] <= eepc_pkg::OPTION_ERASED;
            opt_cell_q[1] <= eepc_pkg::OPTION_ERASED;
        end else if (bus.wr && bootloader_i) begin
            if (bus.addr == eepc_pkg::OPTION_LOW_OFFSET) opt_cell_q[0] <= bus.wdata;
            if (bus.addr == eepc_pkg::OPTION_HIGH_OFFSET) opt_cell_q[1] <= bus.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_cnt_q <= 24'h000000;
            opt_lat_q[0] <= eepc_pkg::OPTION_ERASED;
            opt_lat_q[1] <= eepc_pkg::OPTION_ERASED;
        end else if (ref_cnt_q >= 24'((por_active_i ? POR_CYC : RUN_CYC) - 1)) begin
            ref_cnt_q <= 24'h000000;
            opt_lat_q[0] <= opt_cell_q[0];
            opt_lat_q[1] <= opt_cell_q[1];
        end else begin
            ref_cnt_q <= ref_cnt_q + 24'h000001;
        end
    end

    // ----------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            if (bus.addr == eepc_pkg::PROG_CTRL_OFFSET) rdata_q <= ctrl_q;
            else if (bus.addr == eepc_pkg::OPTION_LOW_OFFSET) rdata_q <= opt_cell_q[0];
            else if (bus.addr == eepc_pkg::OPTION_HIGH_OFFSET) rdata_q <= opt_cell_q[1];
            else if (in_array(bus.addr) && !(latch && captured_q)) begin
                rdata_q <= mem_q[arr_off[6:0]];
            end else rdata_q <= 8'h00;
        end
    end
    assign bus.rdata = rdata_q;

    assign pump_on_o = ctrl_q[eepc_pkg::BIT_PUMP];
    assign erase_mode_o = mode;
    assign prog_power_o = power;
    assign rc_clock_select_o = ctrl_q[eepc_pkg::BIT_RC];
    assign rc_osc_run_o = ctrl_q[eepc_pkg::BIT_RC] && !stop_mode_i;
    // Low byte: watchdog, irq, order, rate, halt, lvr, clock out
    assign watchdog_option_o = opt_lat_q[0][0];
    assign irq_sensitivity_option_o = opt_lat_q[0][1];
    assign bit_order_option_o = opt_lat_q[0][2];
    assign serial_rate_o = opt_lat_q[0][4:3];
    assign stop_to_halt_option_o = opt_lat_q[0][5];
    assign low_voltage_reset_option_o = opt_lat_q[0][6];
    assign clock_output_option_o = opt_lat_q[0][7];
    assign port_a_pullup_option_o = opt_lat_q[1];
endmodule : eepc_device
`default_nettype wire

// ===== eepc_if.sv
// Interface: internal CPU bus between the controller and the array control.
// Assumes one shared clock; reads answer in the next cycle.
`default_nettype none
interface eepc_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport ctl (output addr, output wdata, output wr, output rd, input rdata);
endinterface : eepc_if
`default_nettype wire

// ===== eepc_pkg.sv
// Package: constants shared by both ends of the program/erase control link.
// Assumes a 40 MHz system clock; all ends include this file first.
`default_nettype none
package eepc_pkg;
    localparam int unsigned CLK_MHZ = 40;
    localparam logic [15:0] PROG_CTRL_OFFSET = 16'h001c;
    localparam logic [15:0] ARRAY_BASE = 16'h0140;
    localparam logic [15:0] OPTION_LOW_OFFSET = 16'h3f00;
    localparam logic [15:0] OPTION_HIGH_OFFSET = 16'h3f01;
    localparam int unsigned ARRAY_BYTES = 128;
    localparam int unsigned BLOCK_BYTES = 32;
    // Control register bit positions
    localparam int unsigned BIT_PUMP = 0;
    localparam int unsigned BIT_ERASE_LO = 1;
    localparam int unsigned BIT_ERASE_HI = 2;
    localparam int unsigned BIT_LATCH = 3;
    localparam int unsigned BIT_RC = 4;
    localparam int unsigned BIT_POWER = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] OPTION_ERASED = 8'h00;
    // Option refresh periods in microseconds, then in clock cycles
    localparam int unsigned REFRESH_POR_US = 256;
    localparam int unsigned REFRESH_RUN_US = 16000;
    localparam int unsigned REFRESH_POR_CYC = REFRESH_POR_US * CLK_MHZ;
    localparam int unsigned REFRESH_RUN_CYC = REFRESH_RUN_US * CLK_MHZ;
    // Host command port register indices
    localparam logic [3:0] CMD_ADDR = 4'h0;
    localparam logic [3:0] CMD_DATA = 4'h1;
    localparam logic [3:0] CMD_GO = 4'h2;
    localparam logic [3:0] CMD_STATUS = 4'h3;
    localparam logic [3:0] CMD_RDATA = 4'h4;
    localparam logic [3:0] CMD_OPTLO = 4'h5;
    localparam logic [3:0] CMD_OPTHI = 4'h6;
    typedef enum logic [1:0] {
        EEPC_PROGRAM = 2'b00,
        EEPC_BYTE_ERASE = 2'b01,
        EEPC_BLOCK_ERASE = 2'b10,
        EEPC_BULK_ERASE = 2'b11
    } eepc_mode_type;
endpackage : eepc_pkg
`default_nettype wire

// ===== testbench.sv
// Testbench: drives the controller's software port, checks the array and options.
// Assumes the controller and device ends meet through one link interface.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] sw_addr_i = 4'h0;
    logic [7:0] sw_wdata_i = 8'h00;
    logic sw_wr_i = 1'b0;
    logic sw_rd_i = 1'b0;
    logic [7:0] sw_rdata_o;
    logic por_active_i = 1'b1;
    logic stop_mode_i = 1'b0;
    logic bootloader_i = 1'b0;
    logic pump_on_o, rc_clock_select_o, rc_osc_run_o, prog_power_o;
    logic [1:0] erase_mode_o, serial_rate_o;
    logic watchdog_option_o, irq_sensitivity_option_o, bit_order_option_o;
    logic stop_to_halt_option_o, low_voltage_reset_option_o, clock_output_option_o;
    logic [7:0] port_a_pullup_option_o;
    logic [7:0] v;
    int error_cnt = 0;
    int check_count = 0;
    always #12.5 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // Ends, link and checker
    // ------------------------------------------------------------
    eepc_if u_eepc_if ();
    eepc_device #(.POR_CYC(8), .RUN_CYC(16)) u_eepc_device (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(u_eepc_if), .por_active_i(por_active_i),
        .bootloader_i(bootloader_i), .stop_mode_i(stop_mode_i), .pump_on_o(pump_on_o),
        .rc_clock_select_o(rc_clock_select_o), .rc_osc_run_o(rc_osc_run_o),
        .prog_power_o(prog_power_o), .erase_mode_o(erase_mode_o),
        .watchdog_option_o(watchdog_option_o),
        .irq_sensitivity_option_o(irq_sensitivity_option_o),
        .bit_order_option_o(bit_order_option_o), .serial_rate_o(serial_rate_o),
        .stop_to_halt_option_o(stop_to_halt_option_o),
        .low_voltage_reset_option_o(low_voltage_reset_option_o),
        .clock_output_option_o(clock_output_option_o),
        .port_a_pullup_option_o(port_a_pullup_option_o));
    // Default durations on both, so the checker's limits match the controller's
    eepc_ctl u_eepc_ctl (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(u_eepc_if), .sw_addr_i(sw_addr_i),
        .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
        .sw_rdata_o(sw_rdata_o));
    eepc_assertions u_eepc_assertions (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr(u_eepc_if.addr),
        .wdata(u_eepc_if.wdata), .wr(u_eepc_if.wr), .rd(u_eepc_if.rd),
        .rdata(u_eepc_if.rdata), .pump_on_o(pump_on_o), .prog_power_o(prog_power_o),
        .erase_mode_o(erase_mode_o));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sw_addr_i <= a;
        sw_wdata_i <= d;
        sw_wr_i <= 1'b1;
        @(posedge clk_i);
        sw_wr_i <= 1'b0;
    endtask : sw_write
    task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        sw_addr_i <= a;
        sw_rd_i <= 1'b1;
        @(posedge clk_i);
        sw_rd_i <= 1'b0;
        #1;
        d = sw_rdata_o;
    endtask : sw_read
    task automatic wait_done();
        logic [7:0] s;
        repeat (4) @(posedge clk_i);
        // Bounded poll: a stuck busy is caught here rather than by the watchdog
        for (int i = 0; i < 400; i++) begin
            sw_read(eepc_pkg::CMD_STATUS, s);
            if (s[0] === 1'b0) break;
        end
        check("status", s, 8'h02);
    endtask : wait_done
    task automatic run_op(input eepc_pkg::eepc_mode_type m, input logic [7:0] idx,
            input logic [7:0] d);
        sw_write(eepc_pkg::CMD_ADDR, idx);
        sw_write(eepc_pkg::CMD_DATA, d);
        sw_write(eepc_pkg::CMD_GO, {6'h00, m});
        wait_done();
    endtask : run_op
    task automatic expect_byte(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        sw_write(eepc_pkg::CMD_ADDR, idx);
        repeat (4) @(posedge clk_i);
        sw_read(eepc_pkg::CMD_RDATA, d);
        check("array", d, exp);
    endtask : expect_byte
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        sw_read(eepc_pkg::CMD_STATUS, v);
        check("status_reset", v, 8'h00);
        // User mode: the option write must leave the cell erased
        sw_write(eepc_pkg::CMD_OPTLO, 8'ha5);
        sw_read(eepc_pkg::CMD_OPTLO, v);
        check("opt_low_user", v, eepc_pkg::OPTION_ERASED);
        sw_read(eepc_pkg::CMD_OPTHI, v);
        check("opt_high", v, eepc_pkg::OPTION_ERASED);
        sw_read(4'hf, v);
        check("unmapped", v, 8'h00);
        @(posedge clk_i);
        bootloader_i <= 1'b1;
        sw_write(eepc_pkg::CMD_OPTLO, 8'h6d);
        sw_write(eepc_pkg::CMD_OPTHI, 8'h81);
        sw_read(eepc_pkg::CMD_OPTLO, v);
        check("opt_low_boot", v, 8'h6d);
        sw_read(eepc_pkg::CMD_OPTHI, v);
        check("opt_high_boot", v, 8'h81);
        @(posedge clk_i);
        bootloader_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        v = {clock_output_option_o, low_voltage_reset_option_o,
            stop_to_halt_option_o, serial_rate_o, bit_order_option_o,
            irq_sensitivity_option_o, watchdog_option_o};
        check("opt_latch", v, 8'h6d);
        check("port_a", port_a_pullup_option_o, 8'h81);
        por_active_i <= 1'b0;
        run_op(eepc_pkg::EEPC_BULK_ERASE, 8'd5, 8'h00);
        expect_byte(8'd0, 8'hff);
        expect_byte(8'd127, 8'hff);
        run_op(eepc_pkg::EEPC_PROGRAM, 8'd10, 8'h5a);
        run_op(eepc_pkg::EEPC_PROGRAM, 8'd11, 8'h33);
        expect_byte(8'd10, 8'h5a);
        run_op(eepc_pkg::EEPC_PROGRAM, 8'd10, 8'h0f);
        expect_byte(8'd10, 8'h0a);
        run_op(eepc_pkg::EEPC_BYTE_ERASE, 8'd10, 8'h00);
        expect_byte(8'd10, 8'hff);
        expect_byte(8'd11, 8'h33);
        run_op(eepc_pkg::EEPC_PROGRAM, 8'd32, 8'h44);
        run_op(eepc_pkg::EEPC_PROGRAM, 8'd64, 8'h22);
        run_op(eepc_pkg::EEPC_BLOCK_ERASE, 8'd63, 8'h00);
        expect_byte(8'd32, 8'hff);
        expect_byte(8'd64, 8'h22);
        expect_byte(8'd11, 8'h33);
        // Program with the RC clock selected; stop mode must halt the oscillator
        sw_write(eepc_pkg::CMD_ADDR, 8'd12);
        sw_write(eepc_pkg::CMD_DATA, 8'h77);
        sw_write(eepc_pkg::CMD_GO, 8'h04);
        repeat (8) @(posedge clk_i);
        check("rc_select", {7'h00, rc_clock_select_o}, 8'h01);
        check("rc_run", {7'h00, rc_osc_run_o}, 8'h01);
        stop_mode_i <= 1'b1;
        @(posedge clk_i);
        #1;
        check("rc_stop", {7'h00, rc_osc_run_o}, 8'h00);
        stop_mode_i <= 1'b0;
        wait_done();
        expect_byte(8'd12, 8'h77);
        check("ctrl_idle", {3'h0, pump_on_o, prog_power_o, rc_clock_select_o,
            erase_mode_o}, 8'h00);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
